// >>> logic/ccd_cache_directory_control.v
// Directory test, way selection and write enables for a four-way cache.
// Assumes requesters on the pclk domain and an APB master for registers.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.vh"
module ccd_cache_directory_control
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire eu_req,
  input wire [1:0] eu_op,
  input wire [12:0] eu_page,
  input wire [8:0] eu_index,
  input wire eu_abort,
  input wire page_fail,
  input wire [3:0] page_fail_code,
  output reg eu_done,
  output reg page_fail_hold,
  output reg cache_data_we,
  input wire aux_req,
  input wire [1:0] aux_kind,
  input wire [12:0] aux_page,
  input wire [8:0] aux_index,
  input wire clear_all_pages,
  output reg aux_done,
  output reg core_read_start,
  output reg [3:0] core_word_request,
  output reg [1:0] core_addr_low,
  input wire core_done,
  output reg writeback_start,
  input wire writeback_done,
  output reg queue_load,
  output reg [3:0] buffer_write_request_queue,
  output reg [3:0] cache_to_buffer_queue,
  output reg [12:0] directory_address_mixer,
  output reg [3:0] per_way_hit,
  output reg any_hit,
  output reg read_word_hit,
  output reg any_dirty_hit,
  output reg victim_dirty,
  output reg [3:0] word_valid_flags,
  output reg [3:0] word_dirty_flags,
  output reg [3:0] way_write_enable
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_T0 = 4'h1;
  localparam [3:0] S_T1 = 4'h2;
  localparam [3:0] S_T2 = 4'h3;
  localparam [3:0] S_T3 = 4'h4;
  localparam [3:0] S_PF2 = 4'h5;
  localparam [3:0] S_PF3 = 4'h6;
  localparam [3:0] S_WB = 4'h7;
  localparam [3:0] S_CLR = 4'h8;
  localparam [3:0] S_CORE = 4'h9;
  localparam [3:0] S_WR3 = 4'hA;
  localparam [3:0] S_WR4 = 4'hB;
  localparam [3:0] S_A0 = 4'hC;
  localparam [3:0] S_A1 = 4'hD;
  localparam [3:0] S_A2 = 4'hE;
  localparam [3:0] S_A3 = 4'hF;

  reg [12:0] dir_page [0:`CCD_ENT_N-1];
  reg [3:0] dir_val [0:`CCD_ENT_N-1];
  reg [3:0] dir_wr [0:`CCD_ENT_N-1];
  reg [7:0] lru_age [0:`CCD_LINE_N-1];

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] way_q;
  reg [1:0] way_d;
  reg [1:0] op_q;
  reg [1:0] kind_q;
  reg all_q;
  reg aux_q;
  reg wbfirst_q;
  reg [12:0] page_q;
  reg [8:0] idx_q;
  reg [31:0] ctrl_q;
  reg [25:0] err_q;

  wire [6:0] line = idx_q[8:2];
  wire [1:0] wd = idx_q[1:0];
  wire en = ctrl_q[0];
  wire is_rd = (op_q == `CCD_OP_READ);
  wire is_wr = (op_q == `CCD_OP_WRITE);
  wire forcing = (state_q == S_WB) || (state_q == S_CORE) ||
                 (state_q == S_CLR) ||
                 (aux_q && all_q && (kind_q == `CCD_KIND_CLEAR));

  reg [3:0] hit_c;
  reg [3:0] rdv_c;
  reg [3:0] force_c;
  reg [1:0] hitway_c;
  reg [1:0] victim_c;
  reg [8:0] ent;
  reg [1:0] ak;
  integer k;

  // A forced hit ignores the comparators so a stale match on another way
  // cannot steer a writeback or refill to the wrong place.
  always @*
  begin
    hit_c = 4'h0;
    rdv_c = 4'h0;
    force_c = 4'h0;
    hitway_c = 2'h0;
    victim_c = 2'h0;
    ent = 9'h000;
    ak = 2'h0;
    if (aux_q && all_q && (kind_q == `CCD_KIND_CLEAR))
      force_c[wd] = 1'b1;
    else
      force_c[way_q] = 1'b1;
    for (k = 0; k < 4; k = k + 1)
    begin
      ent = {line, k[1:0]};
      if (forcing)
        hit_c[k] = force_c[k];
      else
        hit_c[k] = (dir_page[ent] == page_q) && (|dir_val[ent]);
      rdv_c[k] = hit_c[k] && dir_val[ent][wd];
      ak = lru_age[line][2*k +: 2];
      if (ak == 2'h3)
        victim_c = k[1:0];
    end
    for (k = 0; k < 4; k = k + 1)
    begin
      if (hit_c[k])
        hitway_c = k[1:0];
    end
  end

  wire any_hit_c = |hit_c;
  wire rd_hit_c = |rdv_c;
  wire [1:0] sel_way = any_hit_c ? hitway_c : victim_c;
  wire [8:0] sel_ent = {line, sel_way};
  wire [8:0] vic_ent = {line, victim_c};
  wire [8:0] hold_ent = {line, way_q};
  wire [3:0] val_c = dir_val[sel_ent];
  wire [3:0] wrt_c = dir_wr[sel_ent];
  wire dirty_hit_c = any_hit_c && (|wrt_c);
  wire vic_dirty_c = |dir_wr[vic_ent];
  wire t2_need_wb = !any_hit_c && vic_dirty_c;

  function [7:0] lru_touch;
    input [7:0] a;
    input [1:0] w;
    reg [1:0] old;
    reg [1:0] cur;
    integer j;
    begin
      old = a[2*w +: 2];
      lru_touch = a;
      for (j = 0; j < 4; j = j + 1)
      begin
        cur = a[2*j +: 2];
        if (j == w)
          lru_touch[2*j +: 2] = 2'h0;
        else if (cur < old)
          lru_touch[2*j +: 2] = cur + 2'h1;
      end
    end
  endfunction

  always @*
  begin
    state_d = state_q;
    way_d = way_q;
    case (state_q)
      S_IDLE:
      begin
        if (en && eu_req && !eu_done)
          state_d = S_T0;
        else if (en && aux_req && !aux_done)
          state_d = S_A0;
      end
      S_T0:
        state_d = eu_abort ? S_IDLE : S_T1;
      S_T1:
        state_d = eu_abort ? S_IDLE : S_T2;
      S_T2:
      begin
        way_d = sel_way;
        if (eu_abort || op_q == `CCD_OP_NONMEM)
          state_d = eu_abort ? S_IDLE : S_T3;
        else if (page_fail)
          state_d = S_PF2;
        else if (t2_need_wb)
          state_d = S_WB;
        else if (is_wr)
          state_d = any_hit_c ? S_WR3 : S_CLR;
        else if (rd_hit_c)
          state_d = S_T3;
        else
          state_d = any_hit_c ? S_CORE : S_CLR;
      end
      S_T3:
        state_d = S_IDLE;
      S_PF2:
        state_d = S_PF3;
      S_PF3:
        state_d = S_IDLE;
      S_WB:
      begin
        if (writeback_done)
          state_d = aux_q ? S_IDLE : S_CLR;
      end
      S_CLR:
        state_d = is_wr ? S_WR3 : S_CORE;
      S_CORE:
      begin
        if (core_done)
          state_d = S_IDLE;
      end
      S_WR3:
        state_d = S_WR4;
      S_WR4:
        state_d = S_IDLE;
      S_A0:
        state_d = S_A1;
      S_A1:
        state_d = S_A2;
      S_A2:
        state_d = S_A3;
      S_A3:
      begin
        way_d = sel_way;
        if (kind_q == `CCD_KIND_CLEAR && dirty_hit_c)
          state_d = S_WB;
        else
          state_d = S_IDLE;
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  wire holding_d = (state_d == S_WB) || (state_d == S_CORE) ||
                   (state_d == S_CLR) || (state_d == S_WR3) ||
                   (state_d == S_WR4);
  wire enter_core = (state_q == S_T2 && state_d == S_CORE) ||
                    (state_q == S_T2 && state_d == S_CLR && is_rd) ||
                    (state_q == S_CLR && is_rd && wbfirst_q);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      way_q <= 2'h0;
      op_q <= 2'h0;
      kind_q <= 2'h0;
      all_q <= 1'b0;
      aux_q <= 1'b0;
      wbfirst_q <= 1'b0;
      page_q <= 13'h0000;
      idx_q <= 9'h000;
      err_q <= 26'h000_0000;
      eu_done <= 1'b0;
      aux_done <= 1'b0;
      page_fail_hold <= 1'b0;
      cache_data_we <= 1'b0;
      core_read_start <= 1'b0;
      core_word_request <= 4'h0;
      core_addr_low <= 2'h0;
      writeback_start <= 1'b0;
      queue_load <= 1'b0;
      buffer_write_request_queue <= 4'h0;
      cache_to_buffer_queue <= 4'h0;
      directory_address_mixer <= 13'h0000;
      per_way_hit <= 4'h0;
      any_hit <= 1'b0;
      read_word_hit <= 1'b0;
      any_dirty_hit <= 1'b0;
      victim_dirty <= 1'b0;
      word_valid_flags <= 4'h0;
      word_dirty_flags <= 4'h0;
      way_write_enable <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      way_q <= way_d;
      eu_done <= (state_d == S_IDLE) && !aux_q &&
                 (state_q != S_IDLE);
      aux_done <= (state_d == S_IDLE) && aux_q &&
                  (state_q != S_IDLE);
      per_way_hit <= hit_c;
      any_hit <= any_hit_c;
      read_word_hit <= rd_hit_c;
      any_dirty_hit <= dirty_hit_c;
      victim_dirty <= vic_dirty_c;
      word_valid_flags <= val_c;
      word_dirty_flags <= wrt_c;
      directory_address_mixer <= dir_page[{line, way_d}];
      way_write_enable <= 4'h0;
      if (holding_d)
        way_write_enable[way_d] <= 1'b1;
      cache_data_we <= (state_d == S_WR3) || (state_d == S_WR4);
      core_read_start <= enter_core;
      if (enter_core)
      begin
        // A fresh or cleared entry has no valid words, so all four go.
        if (state_q == S_T2 && any_hit_c)
          core_word_request <= ~val_c;
        else
          core_word_request <= 4'hF;
        core_addr_low <= wd;
      end
      writeback_start <= (state_d == S_WB) && (state_q != S_WB);
      queue_load <= 1'b0;
      if ((state_d == S_WB) && (state_q != S_WB))
      begin
        queue_load <= 1'b1;
        buffer_write_request_queue <= wrt_c;
        cache_to_buffer_queue <= wrt_c;
      end
      else if (state_q == S_A3 && any_hit_c &&
               (kind_q == `CCD_KIND_CHAN || kind_q == `CCD_KIND_REFILL))
      begin
        queue_load <= 1'b1;
        buffer_write_request_queue <= val_c;
        cache_to_buffer_queue <= val_c;
      end
      if (state_q == S_T2 && state_d == S_WB)
        wbfirst_q <= 1'b1;
      else if (state_d == S_IDLE)
        wbfirst_q <= 1'b0;
      if (state_q == S_PF2)
        err_q <= {page_fail_code, page_q, idx_q};
      if (state_q == S_PF3)
        page_fail_hold <= 1'b1;
      if (state_q == S_IDLE && state_d == S_T0)
      begin
        page_fail_hold <= 1'b0;
        op_q <= eu_op;
        page_q <= eu_page;
        idx_q <= eu_index;
        aux_q <= 1'b0;
        all_q <= 1'b0;
      end
      else if (state_q == S_IDLE && state_d == S_A0)
      begin
        op_q <= `CCD_OP_NONMEM;
        kind_q <= aux_kind;
        all_q <= clear_all_pages;
        page_q <= aux_page;
        idx_q <= aux_index;
        aux_q <= 1'b1;
      end
    end
  end

  // Directory and use table share one process so each array has a single
  // writer; only the bits, not the page addresses, need a reset value.
  integer e;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (e = 0; e < `CCD_ENT_N; e = e + 1)
      begin
        dir_val[e] <= 4'h0;
        dir_wr[e] <= 4'h0;
      end
      for (e = 0; e < `CCD_LINE_N; e = e + 1)
        lru_age[e] <= `CCD_LRU_RST;
    end
    else
    begin
      if (state_q == S_T2 && op_q != `CCD_OP_NONMEM && !page_fail &&
          !eu_abort)
        lru_age[line] <= lru_touch(lru_age[line], sel_way);
      if (state_q == S_CLR)
      begin
        dir_page[hold_ent] <= page_q;
        dir_val[hold_ent] <= 4'h0;
        dir_wr[hold_ent] <= 4'h0;
      end
      else if (state_q == S_WR4)
      begin
        dir_val[hold_ent][wd] <= 1'b1;
        dir_wr[hold_ent][wd] <= 1'b1;
      end
      else if (state_q == S_CORE && core_done)
        dir_val[hold_ent] <= dir_val[hold_ent] | core_word_request;
      else if (state_q == S_WB && writeback_done && aux_q)
        dir_wr[hold_ent] <= 4'h0;
    end
  end

  // Zero-wait slave: read data is captured in the setup cycle.
  wire mapped = (paddr == `CCD_OFF_CTRL) || (paddr == `CCD_OFF_STATUS) ||
                (paddr == `CCD_OFF_ERROR) || (paddr == `CCD_OFF_PAGE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `CCD_CTRL_RST;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (psel && penable && pwrite && paddr == `CCD_OFF_CTRL)
        ctrl_q <= {31'h0000_0000, pwdata[0]};
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `CCD_OFF_CTRL:
            prdata <= ctrl_q;
          `CCD_OFF_STATUS:
            prdata <= {14'h0000, page_fail_hold, word_dirty_flags,
                       word_valid_flags, victim_dirty, any_dirty_hit,
                       any_hit, way_q, state_q};
          `CCD_OFF_ERROR:
            prdata <= {6'h00, err_q};
          `CCD_OFF_PAGE:
            prdata <= {19'h0_0000, directory_address_mixer};
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/ccd_consts.vh
// Constants for the cache directory control block.
// Assumes a 32-bit APB register port with 12-bit byte addresses.
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH
`define CCD_PAGE_W 13
`define CCD_IDX_W 9
`define CCD_LINE_W 7
`define CCD_ENT_N 512
`define CCD_LINE_N 128
`define CCD_OFF_CTRL 12'h000
`define CCD_OFF_STATUS 12'h004
`define CCD_OFF_ERROR 12'h008
`define CCD_OFF_PAGE 12'h00C
`define CCD_CTRL_RST 32'h0000_0001
`define CCD_LRU_RST 8'hE4
`define CCD_OP_READ 2'h0
`define CCD_OP_WRITE 2'h1
`define CCD_OP_NONMEM 2'h2
`define CCD_KIND_CHAN 2'h0
`define CCD_KIND_CLEAR 2'h1
`define CCD_KIND_REFILL 2'h2
`endif

// >>> logic/ccd_unused_guard.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verification/cache_directory_control_test.sv
// Testbench: APB tasks, execution unit model, aux and storage responders.
// Assumes the design's zero-wait APB port and the header's constants.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.vh"
module cache_directory_control_test;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, e, ok, eu_req, eu_abort, page_fail;
  logic [1:0] eu_op, aux_kind = 2'h0, core_addr_low;
  logic [12:0] eu_page, aux_page = 13'h0000, dam, last_dam;
  logic [8:0] eu_index, aux_index = 9'h000;
  logic [3:0] page_fail_code, core_word_request, bq, cq, whit, wv, wd, wwe;
  logic [3:0] last_req, last_bq, last_cq;
  logic eu_done, fail_hold, data_we, aux_req = 1'b0, aux_done;
  logic core_read_start, core_done = 1'b0, wb_start, wb_done = 1'b0;
  logic queue_load, ahit, rhit, dhit, vdirty;
  logic clear_all = 1'b0;
  logic [2:0] cdly = 3'd0, wdly = 3'd0;
  int n_core = 0, n_wb = 0, n_prev, miscompares = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  ccd_cache_directory_control dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .eu_req(eu_req), .eu_op(eu_op), .eu_page(eu_page), .eu_index(eu_index),
    .eu_abort(eu_abort), .page_fail(page_fail),
    .page_fail_code(page_fail_code), .eu_done(eu_done),
    .page_fail_hold(fail_hold), .cache_data_we(data_we), .aux_req(aux_req),
    .aux_kind(aux_kind), .aux_page(aux_page), .aux_index(aux_index),
    .clear_all_pages(clear_all), .aux_done(aux_done),
    .core_read_start(core_read_start), .core_word_request(core_word_request),
    .core_addr_low(core_addr_low), .core_done(core_done),
    .writeback_start(wb_start), .writeback_done(wb_done),
    .queue_load(queue_load), .buffer_write_request_queue(bq),
    .cache_to_buffer_queue(cq), .directory_address_mixer(dam),
    .per_way_hit(whit), .any_hit(ahit), .read_word_hit(rhit),
    .any_dirty_hit(dhit), .victim_dirty(vdirty), .word_valid_flags(wv),
    .word_dirty_flags(wd), .way_write_enable(wwe));
  ccd_eu_model eu_u (.pclk(pclk), .eu_done(eu_done), .eu_req(eu_req),
    .eu_op(eu_op), .eu_page(eu_page), .eu_index(eu_index),
    .eu_abort(eu_abort), .page_fail(page_fail),
    .page_fail_code(page_fail_code));
  // Storage side: answers core reads and writebacks four cycles late.
  always @(posedge pclk)
  begin
    core_done <= (cdly == 3'd1);
    wb_done <= (wdly == 3'd1);
    cdly <= (cdly != 3'd0) ? cdly - 3'd1 : 3'd0;
    wdly <= (wdly != 3'd0) ? wdly - 3'd1 : 3'd0;
    if (core_read_start === 1'b1)
    begin
      n_core <= n_core + 1;
      last_req <= core_word_request;
      cdly <= 3'd4;
    end
    if (wb_start === 1'b1)
    begin
      n_wb <= n_wb + 1;
      last_bq <= bq;
      last_dam <= dam;
      wdly <= 3'd4;
    end
    else if (queue_load === 1'b1)
      last_cq <= cq;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task aux(input logic [1:0] k, input logic [12:0] pg, input logic [8:0] ix,
           input logic all);
    @(posedge pclk);
    aux_req <= 1'b1;
    aux_kind <= k;
    aux_page <= pg;
    aux_index <= ix;
    clear_all <= all;
    do @(posedge pclk); while (aux_done !== 1'b1);
    aux_req <= 1'b0;
  endtask
  task eu(input logic [1:0] op, input logic [12:0] pg, input logic [8:0] ix,
          input logic f);
    eu_u.start(op, pg, ix, f);
    eu_u.finish(100, ok);
    chk(ok, 1);
  endtask
  task status_way(input logic [1:0] w);
    apb(1'b0, `CCD_OFF_STATUS, 32'h0000_0000);
    chk(r[5:4], w);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge pclk);
    miscompares++;
    end_of_test;
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({pready, eu_done, wwe}, 32'h0000_0020);
    apb(1'b0, `CCD_OFF_CTRL, 32'h0000_0000);
    chk(r, `CCD_CTRL_RST);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    apb(1'b1, `CCD_OFF_CTRL, 32'h0000_0000);
    // Disabled: the read must wait, then run as a clean read miss.
    eu_u.start(`CCD_OP_READ, 13'h0011, 9'h004, 1'b0);
    eu_u.finish(12, ok);
    chk(ok, 0);
    apb(1'b1, `CCD_OFF_CTRL, 32'h0000_0001);
    eu_u.finish(100, ok);
    chk({ok, last_req}, 32'h0000_001F);
    status_way(2'h3);
    eu(`CCD_OP_WRITE, 13'h0011, 9'h005, 1'b0);
    n_prev = n_core;
    eu(`CCD_OP_READ, 13'h0011, 9'h005, 1'b0);
    chk(n_core, n_prev);
    chk({rhit, whit}, 5'h18);
    apb(1'b0, `CCD_OFF_STATUS, 32'h0000_0000);
    chk(r[16:6], {4'h2, 4'hF, 3'h3});
    eu(`CCD_OP_READ, 13'h0022, 9'h006, 1'b0);
    chk(last_req, 4'hF);
    chk(core_addr_low, 2'h2);
    status_way(2'h2);
    n_prev = n_wb;
    aux(`CCD_KIND_CLEAR, 13'h0011, 9'h004, 1'b0);
    chk(n_wb - n_prev, 1);
    chk({last_bq, last_dam}, {4'h2, 13'h0011});
    aux(`CCD_KIND_CLEAR, 13'h0011, 9'h004, 1'b0);
    chk(n_wb - n_prev, 1);
    aux(`CCD_KIND_CHAN, 13'h0011, 9'h004, 1'b0);
    // The responder latches the queue one edge after the load pulse.
    @(posedge pclk);
    chk(last_cq, 4'hF);
    eu(`CCD_OP_WRITE, 13'h0033, 9'h004, 1'b0);
    status_way(2'h1);
    n_prev = n_wb;
    aux(`CCD_KIND_CLEAR, 13'h0077, 9'h005, 1'b1);
    chk(n_wb - n_prev, 1);
    chk({last_bq, last_dam}, {4'h1, 13'h0033});
    eu(`CCD_OP_READ, 13'h0055, 9'h007, 1'b1);
    chk(fail_hold, 1);
    apb(1'b0, `CCD_OFF_ERROR, 32'h0000_0000);
    chk(r, {6'h00, 4'hA, 13'h0055, 9'h007});
    eu(`CCD_OP_NONMEM, 13'h0011, 9'h004, 1'b0);
    chk(fail_hold, 0);
    end_of_test;
  end
endmodule
`default_nettype wire

// >>> verification/ccd_cache_directory_control_monitor.sv
// Port-level checker for the cache directory control block.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ccd_monitor
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire eu_done,
  input wire page_fail_hold,
  input wire cache_data_we,
  input wire core_read_start,
  input wire [3:0] core_word_request,
  input wire writeback_start,
  input wire queue_load,
  input wire aux_done,
  input wire [3:0] per_way_hit,
  input wire any_hit,
  input wire read_word_hit,
  input wire any_dirty_hit,
  input wire [3:0] word_dirty_flags,
  input wire [3:0] way_write_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_way_hit: assert property ($onehot0(per_way_hit))
    else $error("more than one way hit");
  a_any_hit_or: assert property (any_hit == (|per_way_hit))
    else $error("any hit differs from per-way hits");
  a_read_hit_way: assert property (read_word_hit |-> any_hit)
    else $error("read hit without a way hit");
  a_dirty_hit_bits: assert property
    (any_dirty_hit |-> word_dirty_flags != 4'h0)
    else $error("dirty hit without written words");
  a_core_req_held: assert property
    (core_read_start |=> $stable(core_word_request)[*3])
    else $error("core word request moved during core read");
  a_write_two: assert property
    ($rose(cache_data_we) |-> way_write_enable != 4'h0
    ##1 (cache_data_we && $stable(way_write_enable)) ##1 !cache_data_we)
    else $error("cache write not two cycles on one way");
  a_wb_load: assert property (writeback_start |-> queue_load)
    else $error("writeback without queue load");
  a_wb_way_held: assert property
    (writeback_start |-> ##1 (way_write_enable != 4'h0)[*2])
    else $error("way enable not held in writeback");
  a_we_onehot: assert property ($onehot0(way_write_enable))
    else $error("more than one way write enable");
  a_fail_done: assert property ($rose(page_fail_hold) |-> eu_done)
    else $error("page fail hold without cycle end");
  a_unmapped_err: assert property
    (psel && penable |->
     pslverr == ((paddr[1:0] != 2'h0) || (paddr > 12'h00C)))
    else $error("slave error on wrong address");
  c_writeback: cover property (writeback_start);
  c_core_read: cover property (core_read_start);
  c_page_fail: cover property ($rose(page_fail_hold));
  c_aux_end: cover property (aux_done);
endmodule
bind ccd_cache_directory_control ccd_monitor mon_u (.*);
`default_nettype wire

// >>> verification/ccd_eu_model.sv
// Execution unit model: issues one request at a time and waits for its end.
// Assumes the bench calls start, then finish, from one process.
`timescale 1ns/1ps
`default_nettype none
module ccd_eu_model
(
  input wire logic pclk,
  input wire logic eu_done,
  output logic eu_req,
  output logic [1:0] eu_op,
  output logic [12:0] eu_page,
  output logic [8:0] eu_index,
  output logic eu_abort,
  output logic page_fail,
  output logic [3:0] page_fail_code
);
  initial
  begin
    eu_req = 1'b0;
    eu_op = 2'h0;
    eu_page = 13'h0000;
    eu_index = 9'h000;
    eu_abort = 1'b0;
    page_fail = 1'b0;
    page_fail_code = 4'h0;
  end
  task start(input logic [1:0] op, input logic [12:0] pg,
             input logic [8:0] ix, input logic f);
    @(posedge pclk);
    eu_req <= 1'b1;
    eu_op <= op;
    eu_page <= pg;
    eu_index <= ix;
    page_fail <= f;
    page_fail_code <= f ? 4'hA : 4'h0;
  endtask
  // The request holds until eu_done is sampled; page and index are inverted
  // afterwards so a design that samples them late sees wrong values.
  task finish(input int lim, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++)
    begin
      @(posedge pclk);
      if (eu_done === 1'b1)
        ok = 1'b1;
    end
    if (ok)
    begin
      eu_req <= 1'b0;
      eu_page <= ~eu_page;
      eu_index <= ~eu_index;
      page_fail <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire
